// ==== bmpm_pkg.sv ====
package bmpm_pkg;

  // Page geometry
  localparam int unsigned PAGE_BYTES   = 32;
  localparam int unsigned P1_USER      = 24;
  localparam int unsigned P23_USER     = 8;
  localparam int unsigned USER_TOTAL   = P1_USER + 2 * P23_USER;
  localparam logic [5:0]  P2_IDX_BASE  = 6'h18;
  localparam logic [5:0]  P3_IDX_BASE  = 6'h20;

  // Page numbers as seen in address bits 7:5
  localparam logic [2:0]  PAGE_ONE     = 3'h0;
  localparam logic [2:0]  PAGE_TWO     = 3'h1;
  localparam logic [2:0]  PAGE_THREE   = 3'h2;
  localparam logic [2:0]  PAGE_REGS    = 3'h3;
  localparam logic [2:0]  PAGE_FIVE    = 3'h4;

  // Byte addresses
  localparam logic [7:0]  ADDR_P1_LAST = 8'h17;
  localparam logic [7:0]  ADDR_P1_RSV  = 8'h18;
  localparam logic [7:0]  ADDR_TEMP_LO = 8'h60;
  localparam logic [7:0]  ADDR_TEMP_HI = 8'h61;
  localparam logic [7:0]  ADDR_STAT_LO = 8'h62;
  localparam logic [7:0]  ADDR_STAT_HI = 8'h63;
  localparam logic [7:0]  ADDR_VOLT_LO = 8'h77;
  localparam logic [7:0]  ADDR_VOLT_HI = 8'h78;
  localparam logic [7:0]  ADDR_MAKER_LO = 8'h80;
  localparam logic [7:0]  ADDR_MAKER_HI = 8'h81;
  localparam logic [7:0]  ADDR_CYC_LO  = 8'h82;
  localparam logic [7:0]  ADDR_CYC_HI  = 8'h83;
  localparam logic [7:0]  ADDR_LAST    = 8'h9f;

  // Status byte fields and the reserved read value
  localparam int unsigned STAT_TEMP_BUSY_BIT   = 0;
  localparam int unsigned STAT_EEPROM_BUSY_BIT = 1;
  localparam int unsigned STAT_LOCK_BIT        = 2;
  localparam int unsigned STAT_CONV_BUSY_BIT   = 3;
  localparam logic [7:0]  STAT_HI_VALUE = 8'hff;
  localparam logic [7:0]  RESERVED_READ = 8'hff;

  // Reset values and the cycle count ceiling
  localparam logic [7:0]  BYTE_RESET   = 8'h00;
  localparam logic [15:0] CYC_RESET    = 16'h0000;
  localparam logic [15:0] CYC_MAX      = 16'hffff;

  // Identity values, arbitrary
  localparam logic [63:0] ROM_ID_DEFAULT = 64'h0011_2233_4455_6677;
  localparam logic [15:0] MAKER_DEFAULT  = 16'h5a5a;

  // Timing
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned COPY_MIN_MS  = 2;
  localparam int unsigned COPY_MAX_MS  = 10;
  localparam int unsigned COPY_CYCLES  = (COPY_MIN_MS * CLK_HZ + 999) / 1000;

  typedef enum logic [3:0] {
    BMPM_ROM_READ   = 4'h0,
    BMPM_ROM_MATCH  = 4'h1,
    BMPM_ROM_SEARCH = 4'h2,
    BMPM_ROM_SKIP   = 4'h3,
    BMPM_WR_SP      = 4'h4,
    BMPM_RD_SP      = 4'h5,
    BMPM_COPY_SP    = 4'h6,
    BMPM_RD_MEM     = 4'h7,
    BMPM_LOCK       = 4'h8,
    BMPM_UNLOCK     = 4'h9,
    BMPM_CYC_INC    = 4'ha,
    BMPM_CYC_CLR    = 4'hb,
    BMPM_CONV_T     = 4'hc,
    BMPM_CONV_V     = 4'hd
  } bmpm_op_t;

  typedef enum logic {
    BMPM_SEL_IDLE = 1'b0,
    BMPM_SEL_OPEN = 1'b1
  } bmpm_sel_t;

  typedef enum logic [2:0] {
    BMPM_PEND_NONE   = 3'h0,
    BMPM_PEND_P1     = 3'h1,
    BMPM_PEND_P2     = 3'h2,
    BMPM_PEND_LOCK   = 3'h3,
    BMPM_PEND_UNLOCK = 3'h4
  } bmpm_pend_t;

  typedef struct packed {
    bmpm_op_t    op;
    logic [7:0]  addr;
    logic [7:0]  data;
    logic [63:0] rom_id;
  } bmpm_req_t;

  typedef struct packed {
    logic        ok;
    logic [7:0]  data;
    logic [63:0] rom_id;
  } bmpm_rsp_t;

endpackage : bmpm_pkg

// ==== bmpm_copy_timer.sv ====
`timescale 1ns/1ps
module bmpm_copy_timer
  import bmpm_pkg::*;
#(
  parameter int unsigned CYCLES = COPY_CYCLES
) (
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_start,
  output logic      o_busy,
  output logic      o_done
);

  logic [31:0] cnt_q, cnt_d;
  logic        busy_q, busy_d;
  logic        done_q, done_d;

  // Busy stands exactly CYCLES clocks; a start while busy is ignored
  always_comb begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (busy_q) begin
      if (cnt_q == 32'h1) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q - 32'h1;
      end
    end else if (i_start) begin
      busy_d = 1'b1;
      cnt_d  = CYCLES;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_q  <= 32'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign o_busy = busy_q;
  assign o_done = done_q;

endmodule : bmpm_copy_timer

// ==== bmpm_memory.sv ====
`timescale 1ns/1ps
module bmpm_memory
  import bmpm_pkg::*;
#(
  parameter int unsigned COPY_TIME_CYCLES = COPY_CYCLES,
  parameter logic [63:0] ROM_ID           = ROM_ID_DEFAULT,
  parameter logic [15:0] MAKER_ID         = MAKER_DEFAULT
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_bus_reset,
  input  wire logic        i_req_valid,
  input  wire bmpm_req_t   i_req,
  input  wire logic        i_parasite,
  input  wire logic [15:0] i_temp_value,
  input  wire logic        i_temp_done,
  input  wire logic [15:0] i_volt_value,
  input  wire logic        i_volt_done,
  output logic             o_rsp_valid,
  output bmpm_rsp_t        o_rsp,
  output logic             o_selected,
  output logic             o_conv_temp,
  output logic             o_conv_volt
);

  // Maps a user address onto the shared scratchpad/store index
  function automatic logic [6:0] user_map(input logic [7:0] a);
    logic [6:0] r;
    r = 7'h0;
    if (a[7:5] == PAGE_ONE && a <= ADDR_P1_LAST) begin
      r = {1'b1, a[5:0]};
    end else if (a[7:5] == PAGE_TWO && a[4:3] == 2'b00) begin
      r = {1'b1, P2_IDX_BASE | {3'h0, a[2:0]}};
    end else if (a[7:5] == PAGE_THREE && a[4:3] == 2'b00) begin
      r = {1'b1, P3_IDX_BASE | {3'h0, a[2:0]}};
    end
    return r;
  endfunction : user_map

  function automatic logic is_mem_op(input bmpm_op_t op);
    return op >= BMPM_WR_SP;
  endfunction : is_mem_op

  bmpm_sel_t   sel_q, sel_d;
  logic [7:0]  sp_q [USER_TOTAL];
  logic [7:0]  sp_d [USER_TOTAL];
  logic [7:0]  st_q [USER_TOTAL];
  logic [7:0]  st_d [USER_TOTAL];
  logic        lock_q, lock_d;
  logic [15:0] cyc_q, cyc_d;
  logic [15:0] temp_q, temp_d;
  logic [15:0] volt_q, volt_d;
  logic        tbusy_q, tbusy_d;
  logic        abusy_q, abusy_d;
  bmpm_pend_t  pend_q, pend_d;
  logic        rsp_valid_q, rsp_valid_d;
  bmpm_rsp_t   rsp_q, rsp_d;
  logic        conv_t_q, conv_t_d;
  logic        conv_v_q, conv_v_d;
  logic        para_meta_q, para_q;
  logic        nv_busy;
  logic        nv_done;
  logic        nv_start;
  logic [7:0]  status_lo;
  logic [6:0]  umap;

  // Supply detector level crosses in through two flops
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      para_meta_q <= 1'b0;
      para_q      <= 1'b0;
    end else begin
      para_meta_q <= i_parasite;
      para_q      <= para_meta_q;
    end
  end

  bmpm_copy_timer #(
    .CYCLES (COPY_TIME_CYCLES)
  ) u_copy_timer (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_start (nv_start),
    .o_busy  (nv_busy),
    .o_done  (nv_done)
  );

  assign status_lo = {4'h0, abusy_q, lock_q, nv_busy, tbusy_q};
  assign umap      = user_map(i_req.addr);

  always_comb begin
    sel_d       = sel_q;
    sp_d        = sp_q;
    st_d        = st_q;
    lock_d      = lock_q;
    cyc_d       = cyc_q;
    temp_d      = temp_q;
    volt_d      = volt_q;
    tbusy_d     = tbusy_q;
    abusy_d     = abusy_q;
    pend_d      = pend_q;
    rsp_valid_d = 1'b0;
    rsp_d       = '{ok: 1'b0, data: RESERVED_READ, rom_id: 64'h0};
    conv_t_d    = 1'b0;
    conv_v_d    = 1'b0;
    nv_start    = 1'b0;

    // Converter results; done events win over nothing, a new request re-sets below
    if (i_temp_done) begin
      tbusy_d = 1'b0;
      temp_d  = i_temp_value;
    end
    if (i_volt_done) begin
      abusy_d = 1'b0;
      volt_d  = i_volt_value;
    end

    // EEPROM commit at end of the busy window, only for the page or lock change latched
    if (nv_done) begin
      case (pend_q)
        BMPM_PEND_P1:     for (int i = 0; i < P1_USER; i++) st_d[i] = sp_q[i];
        BMPM_PEND_P2:     for (int i = 0; i < P23_USER; i++) begin
          st_d[P2_IDX_BASE + i] = sp_q[P2_IDX_BASE + i];
        end
        BMPM_PEND_LOCK:   lock_d = 1'b1;
        BMPM_PEND_UNLOCK: lock_d = 1'b0;
        default:          lock_d = lock_q;
      endcase
      pend_d = BMPM_PEND_NONE;
    end

    if (i_bus_reset) begin
      sel_d = BMPM_SEL_IDLE;
    end else if (i_req_valid) begin
      rsp_valid_d = 1'b1;
      if (!is_mem_op(i_req.op)) begin
        rsp_d.ok = 1'b1;
        case (i_req.op)
          BMPM_ROM_READ:  begin
            rsp_d.rom_id = ROM_ID;
            sel_d        = BMPM_SEL_OPEN;
          end
          BMPM_ROM_MATCH, BMPM_ROM_SEARCH: begin
            rsp_d.ok = (i_req.rom_id == ROM_ID);
            sel_d    = rsp_d.ok ? BMPM_SEL_OPEN : BMPM_SEL_IDLE;
          end
          default:        sel_d = BMPM_SEL_OPEN;
        endcase
      end else if (sel_q == BMPM_SEL_OPEN) begin
        case (i_req.op)
          BMPM_WR_SP: begin
            if (umap[6] && !para_q) begin
              sp_d[umap[5:0]] = i_req.data;
              rsp_d.ok        = 1'b1;
            end
          end
          BMPM_RD_SP: begin
            if (umap[6]) begin
              rsp_d.data = sp_q[umap[5:0]];
              rsp_d.ok   = 1'b1;
            end
          end
          BMPM_RD_MEM: begin
            rsp_d.ok = (i_req.addr <= ADDR_LAST);
            if (umap[6]) begin
              rsp_d.data = st_q[umap[5:0]];
            end else begin
              case (i_req.addr)
                ADDR_TEMP_LO:  rsp_d.data = temp_q[7:0];
                ADDR_TEMP_HI:  rsp_d.data = temp_q[15:8];
                ADDR_STAT_LO:  rsp_d.data = status_lo;
                ADDR_STAT_HI:  rsp_d.data = STAT_HI_VALUE;
                ADDR_VOLT_LO:  rsp_d.data = volt_q[7:0];
                ADDR_VOLT_HI:  rsp_d.data = volt_q[15:8];
                ADDR_MAKER_LO: rsp_d.data = MAKER_ID[7:0];
                ADDR_MAKER_HI: rsp_d.data = MAKER_ID[15:8];
                ADDR_CYC_LO:   rsp_d.data = cyc_q[7:0];
                ADDR_CYC_HI:   rsp_d.data = cyc_q[15:8];
                default:       rsp_d.data = RESERVED_READ;
              endcase
            end
          end
          BMPM_COPY_SP: begin
            if (!nv_busy && !para_q) begin
              case (i_req.addr[7:5])
                PAGE_ONE: if (!lock_q) begin
                  pend_d   = BMPM_PEND_P1;
                  nv_start = 1'b1;
                  rsp_d.ok = 1'b1;
                end
                PAGE_TWO: begin
                  pend_d   = BMPM_PEND_P2;
                  nv_start = 1'b1;
                  rsp_d.ok = 1'b1;
                end
                PAGE_THREE: begin
                  for (int i = 0; i < P23_USER; i++) begin
                    st_d[P3_IDX_BASE + i] = sp_q[P3_IDX_BASE + i];
                  end
                  rsp_d.ok = 1'b1;
                end
                default: rsp_d.ok = 1'b0;
              endcase
            end
          end
          BMPM_LOCK, BMPM_UNLOCK: begin
            if (!nv_busy && !para_q) begin
              pend_d   = (i_req.op == BMPM_LOCK) ? BMPM_PEND_LOCK : BMPM_PEND_UNLOCK;
              nv_start = 1'b1;
              rsp_d.ok = 1'b1;
            end
          end
          BMPM_CYC_INC, BMPM_CYC_CLR: begin
            if (!nv_busy && !para_q) begin
              if (i_req.op == BMPM_CYC_CLR) begin
                cyc_d = CYC_RESET;
              end else if (cyc_q != CYC_MAX) begin
                cyc_d = cyc_q + 16'h1;
              end
              rsp_d.ok = 1'b1;
            end
          end
          BMPM_CONV_T: begin
            if (!para_q) begin
              tbusy_d  = 1'b1;
              conv_t_d = 1'b1;
              rsp_d.ok = 1'b1;
            end
          end
          BMPM_CONV_V: begin
            if (!para_q) begin
              abusy_d  = 1'b1;
              conv_v_d = 1'b1;
              rsp_d.ok = 1'b1;
            end
          end
          default: rsp_d.ok = 1'b0;
        endcase
      end
      // Unselected memory requests fall through with ok low
    end
  end

  // Stores, lock and counter share one power-on reset with the rest
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sel_q       <= BMPM_SEL_IDLE;
      for (int i = 0; i < USER_TOTAL; i++) begin
        sp_q[i] <= BYTE_RESET;
        st_q[i] <= BYTE_RESET;
      end
      lock_q      <= 1'b0;
      cyc_q       <= CYC_RESET;
      temp_q      <= CYC_RESET;
      volt_q      <= CYC_RESET;
      tbusy_q     <= 1'b0;
      abusy_q     <= 1'b0;
      pend_q      <= BMPM_PEND_NONE;
      rsp_valid_q <= 1'b0;
      rsp_q       <= '0;
      conv_t_q    <= 1'b0;
      conv_v_q    <= 1'b0;
    end else begin
      sel_q       <= sel_d;
      sp_q        <= sp_d;
      st_q        <= st_d;
      lock_q      <= lock_d;
      cyc_q       <= cyc_d;
      temp_q      <= temp_d;
      volt_q      <= volt_d;
      tbusy_q     <= tbusy_d;
      abusy_q     <= abusy_d;
      pend_q      <= pend_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_q       <= rsp_d;
      conv_t_q    <= conv_t_d;
      conv_v_q    <= conv_v_d;
    end
  end

  assign o_rsp_valid = rsp_valid_q;
  assign o_rsp       = rsp_q;
  assign o_selected  = sel_q;
  assign o_conv_temp = conv_t_q;
  assign o_conv_volt = conv_v_q;

  // Length of the current busy window, read only by the checks
  logic [31:0] busy_len_q;
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      busy_len_q <= 32'h0;
    end else begin
      busy_len_q <= nv_busy ? busy_len_q + 32'h1 : 32'h0;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  logic req_sel;
  assign req_sel = i_req_valid && !i_bus_reset && sel_q == BMPM_SEL_OPEN;

  chk_refuse_unsel: assert property (
    i_req_valid && !i_bus_reset && sel_q == BMPM_SEL_IDLE && is_mem_op(i_req.op)
    |=> o_rsp_valid && !o_rsp.ok)
    else $error("memory access accepted before ROM selection");

  chk_answer_next: assert property (
    i_req_valid && !i_bus_reset |=> o_rsp_valid ##1 !o_rsp_valid || $past(i_req_valid))
    else $error("request not answered in the next cycle");

  chk_p1_reserved: assert property (
    req_sel && i_req.op == BMPM_RD_MEM && i_req.addr >= ADDR_P1_RSV
    && i_req.addr[7:5] == PAGE_ONE |=> o_rsp.data == RESERVED_READ)
    else $error("reserved page one byte did not read as ones");

  chk_status_byte: assert property (
    req_sel && i_req.op == BMPM_RD_MEM && i_req.addr == ADDR_STAT_LO
    |=> o_rsp.data[7:4] == 4'h0 && o_rsp.data[STAT_LOCK_BIT] == $past(lock_q))
    else $error("status byte layout wrong");

  chk_busy_window: assert property (
    $fell(nv_busy) |-> $past(busy_len_q) == COPY_TIME_CYCLES - 1)
    else $error("EEPROM busy window has wrong length");

  chk_lock_blocks: assert property (
    req_sel && lock_q && i_req.op == BMPM_COPY_SP && i_req.addr[7:5] == PAGE_ONE
    && !nv_busy |=> !o_rsp.ok ##1 !nv_busy)
    else $error("copy to locked page one accepted");

  chk_scratch_write: assert property (
    req_sel && i_req.op == BMPM_WR_SP && umap[6] && !para_q
    |=> sp_q[$past(umap[5:0])] == $past(i_req.data))
    else $error("scratchpad write lost");

  chk_page3_copy: assert property (
    req_sel && i_req.op == BMPM_COPY_SP && i_req.addr[7:5] == PAGE_THREE && !para_q
    && !nv_busy && !nv_done |=> st_q[P3_IDX_BASE] == $past(sp_q[P3_IDX_BASE])
    && st_q[0] == $past(st_q[0]))
    else $error("page three copy wrong or touched page one");

  chk_match_miss: assert property (
    i_req_valid && !i_bus_reset && i_req.op == BMPM_ROM_MATCH && i_req.rom_id != ROM_ID
    |=> sel_q == BMPM_SEL_IDLE && !o_rsp.ok)
    else $error("mismatched ROM id selected the device");

  chk_cyc_saturate: assert property (
    cyc_q == CYC_MAX && !(i_req_valid && i_req.op == BMPM_CYC_CLR) |=> cyc_q == CYC_MAX)
    else $error("cycle count rolled over");

  cov_copy_p1: cover property (nv_done && pend_q == BMPM_PEND_P1);
  cov_lock_set: cover property ($rose(lock_q));
  cov_match_hit: cover property (
    i_req_valid && i_req.op == BMPM_ROM_MATCH ##1 sel_q == BMPM_SEL_OPEN);
  cov_conv_temp: cover property (o_conv_temp ##[1:50] !tbusy_q);

endmodule : bmpm_memory

// ==== bmpm_conv_model.sv ====
`timescale 1ns/1ps
module bmpm_conv_model #(
  parameter int unsigned DELAY    = 8,
  parameter logic [15:0] TEMP_VAL = 16'h1910,
  parameter logic [15:0] VOLT_VAL = 16'h01f4
) (
  input  wire logic   i_clk,
  input  wire logic   i_reset,
  input  wire logic   i_conv_temp,
  input  wire logic   i_conv_volt,
  output logic        o_temp_done,
  output logic [15:0] o_temp_value,
  output logic        o_volt_done,
  output logic [15:0] o_volt_value
);
  int unsigned t_cnt_q;
  int unsigned v_cnt_q;

  // Results show only with the done pulse; otherwise the inverse is driven
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      t_cnt_q      <= 0;
      v_cnt_q      <= 0;
      o_temp_done  <= 1'b0;
      o_volt_done  <= 1'b0;
      o_temp_value <= ~TEMP_VAL;
      o_volt_value <= ~VOLT_VAL;
    end else begin
      t_cnt_q      <= i_conv_temp ? DELAY : (t_cnt_q > 0 ? t_cnt_q - 1 : 0);
      v_cnt_q      <= i_conv_volt ? DELAY : (v_cnt_q > 0 ? v_cnt_q - 1 : 0);
      o_temp_done  <= (t_cnt_q == 1);
      o_volt_done  <= (v_cnt_q == 1);
      o_temp_value <= (t_cnt_q == 1) ? TEMP_VAL : ~TEMP_VAL;
      o_volt_value <= (v_cnt_q == 1) ? VOLT_VAL : ~VOLT_VAL;
    end
  end
endmodule : bmpm_conv_model

// ==== test_battery_monitor_paged_memory.sv ====
`timescale 1ns/1ps
module test_battery_monitor_paged_memory;
  import bmpm_pkg::*;
  localparam int unsigned COPY_T   = 20;
  localparam logic [63:0] MY_ID    = 64'h1357_9bdf_2468_ace0; // Arbitrary
  localparam logic [15:0] MY_MAKER = 16'hc3a1;                // Arbitrary

  logic        i_clk;
  logic        i_reset;
  logic        i_bus_reset;
  logic        i_req_valid;
  bmpm_req_t   i_req;
  logic        i_parasite;
  logic [15:0] i_temp_value;
  logic        i_temp_done;
  logic [15:0] i_volt_value;
  logic        i_volt_done;
  logic        o_rsp_valid;
  bmpm_rsp_t   o_rsp;
  logic        o_selected;
  logic        o_conv_temp;
  logic        o_conv_volt;
  bmpm_rsp_t   rsp;
  logic        rv;
  logic        ct;
  logic        cv;
  int          miscompares;
  int          cmp_count;
  int          k;
  bmpm_op_t    rom_ops [4] = '{BMPM_ROM_MATCH, BMPM_ROM_SEARCH, BMPM_ROM_SKIP, BMPM_ROM_READ};
  logic [7:0]  rsv [11] = '{8'h18, 8'h1f, 8'h28, 8'h3f, 8'h48, 8'h64, 8'h76, 8'h79,
                            8'h7f, 8'h84, 8'h9f};

  bmpm_memory #(
    .COPY_TIME_CYCLES(COPY_T),
    .ROM_ID          (MY_ID),
    .MAKER_ID        (MY_MAKER)
  ) dut (
    .i_clk       (i_clk),
    .i_reset     (i_reset),
    .i_bus_reset (i_bus_reset),
    .i_req_valid (i_req_valid),
    .i_req       (i_req),
    .i_parasite  (i_parasite),
    .i_temp_value(i_temp_value),
    .i_temp_done (i_temp_done),
    .i_volt_value(i_volt_value),
    .i_volt_done (i_volt_done),
    .o_rsp_valid (o_rsp_valid),
    .o_rsp       (o_rsp),
    .o_selected  (o_selected),
    .o_conv_temp (o_conv_temp),
    .o_conv_volt (o_conv_volt)
  );

  bmpm_conv_model u_conv (
    .i_clk       (i_clk),
    .i_reset     (i_reset),
    .i_conv_temp (o_conv_temp),
    .i_conv_volt (o_conv_volt),
    .o_temp_done (i_temp_done),
    .o_temp_value(i_temp_value),
    .o_volt_done (i_volt_done),
    .o_volt_value(i_volt_value)
  );

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  task automatic chk_ok(input logic g, input logic e);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t flag got %b exp %b", $time, g, e);
    end
  endtask : chk_ok

  task automatic chk_val(input logic [63:0] g, input logic [63:0] e);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t value got %h exp %h", $time, g, e);
    end
  endtask : chk_val

  // One request; the answer is captured in the cycle after the taking edge
  task automatic send(input bmpm_op_t op, input logic [7:0] a, input logic [7:0] d,
                      input logic [63:0] id);
    @(posedge i_clk);
    i_req_valid <= 1'b1;
    i_req       <= '{op: op, addr: a, data: d, rom_id: id};
    @(posedge i_clk);
    i_req_valid <= 1'b0;
    #1;
    rsp = o_rsp;
    rv  = o_rsp_valid;
    ct  = o_conv_temp;
    cv  = o_conv_volt;
    chk_ok(rv, 1'b1);
  endtask : send

  task automatic cmd(input bmpm_op_t op, input logic [7:0] a, input logic [7:0] d,
                     input logic [63:0] id, input logic ok);
    send(op, a, d, id);
    chk_ok(rsp.ok, ok);
  endtask : cmd

  task automatic rd(input bmpm_op_t op, input logic [7:0] a, input logic [7:0] d);
    cmd(op, a, 8'h00, '0, 1'b1);
    chk_val(64'(rsp.data), 64'(d));
  endtask : rd

  task automatic wait_nv();
    int n;
    for (n = 0; n < 100; n++) begin
      send(BMPM_RD_MEM, ADDR_STAT_LO, 8'h00, '0);
      if (rsp.data[STAT_EEPROM_BUSY_BIT] === 1'b0) break;
    end
    if (n == 100) begin
      miscompares++;
      $display("MISMATCH t=%0t busy flag stuck", $time);
      print_verdict();
    end
  endtask : wait_nv

  initial begin
    i_reset     = 1'b1;
    i_bus_reset = 1'b0;
    i_req_valid = 1'b0;
    i_req       = '0;
    i_parasite  = 1'b0;
    miscompares = 0;
    cmp_count   = 0;
    repeat (6) @(posedge i_clk);
    i_reset <= 1'b0;
    cmd(BMPM_RD_MEM, 8'h80, 8'h00, '0, 1'b0);
    cmd(BMPM_WR_SP, 8'h00, 8'h11, '0, 1'b0);
    cmd(BMPM_ROM_MATCH, 8'h00, 8'h00, ~MY_ID, 1'b0);
    chk_ok(o_selected, 1'b0);
    for (k = 0; k < 4; k++) begin
      @(posedge i_clk);
      i_bus_reset <= 1'b1;
      @(posedge i_clk);
      i_bus_reset <= 1'b0;
      cmd(BMPM_RD_MEM, 8'h80, 8'h00, '0, 1'b0);
      cmd(rom_ops[k], 8'h00, 8'h00, MY_ID, 1'b1);
      chk_ok(o_selected, 1'b1);
      rd(BMPM_RD_MEM, ADDR_MAKER_LO, MY_MAKER[7:0]);
    end
    cmd(BMPM_ROM_READ, 8'h00, 8'h00, '0, 1'b1);
    chk_val(rsp.rom_id, MY_ID);
    rd(BMPM_RD_MEM, ADDR_MAKER_HI, MY_MAKER[15:8]);
    for (k = 0; k < 11; k++) rd(BMPM_RD_MEM, rsv[k], 8'hff);
    cmd(BMPM_RD_MEM, 8'ha0, 8'h00, '0, 1'b0);
    cmd(BMPM_WR_SP, ADDR_P1_RSV, 8'h11, '0, 1'b0);
    cmd(BMPM_WR_SP, ADDR_TEMP_LO, 8'h11, '0, 1'b0);
    cmd(BMPM_WR_SP, 8'h00, 8'ha1, '0, 1'b1);
    cmd(BMPM_WR_SP, ADDR_P1_LAST, 8'hb2, '0, 1'b1);
    cmd(BMPM_WR_SP, 8'h27, 8'hc3, '0, 1'b1);
    cmd(BMPM_WR_SP, 8'h40, 8'hd4, '0, 1'b1);
    rd(BMPM_RD_SP, 8'h00, 8'ha1);
    rd(BMPM_RD_SP, ADDR_P1_LAST, 8'hb2);
    rd(BMPM_RD_MEM, 8'h00, 8'h00);
    cmd(BMPM_COPY_SP, 8'h00, 8'h00, '0, 1'b1);
    rd(BMPM_RD_MEM, ADDR_STAT_LO, 8'h02);
    cmd(BMPM_COPY_SP, 8'h20, 8'h00, '0, 1'b0);
    wait_nv();
    rd(BMPM_RD_MEM, 8'h00, 8'ha1);
    rd(BMPM_RD_MEM, ADDR_P1_LAST, 8'hb2);
    rd(BMPM_RD_MEM, 8'h27, 8'h00);
    rd(BMPM_RD_MEM, 8'h40, 8'h00);
    cmd(BMPM_COPY_SP, 8'h20, 8'h00, '0, 1'b1);
    wait_nv();
    rd(BMPM_RD_MEM, 8'h27, 8'hc3);
    cmd(BMPM_COPY_SP, 8'h40, 8'h00, '0, 1'b1);
    rd(BMPM_RD_MEM, 8'h40, 8'hd4);
    cmd(BMPM_LOCK, 8'h00, 8'h00, '0, 1'b1);
    wait_nv();
    rd(BMPM_RD_MEM, ADDR_STAT_LO, 8'h04);
    cmd(BMPM_WR_SP, 8'h00, 8'h5e, '0, 1'b1);
    cmd(BMPM_COPY_SP, 8'h00, 8'h00, '0, 1'b0);
    rd(BMPM_RD_MEM, 8'h00, 8'ha1);
    cmd(BMPM_COPY_SP, 8'h20, 8'h00, '0, 1'b1);
    wait_nv();
    cmd(BMPM_UNLOCK, 8'h00, 8'h00, '0, 1'b1);
    wait_nv();
    rd(BMPM_RD_MEM, ADDR_STAT_LO, 8'h00);
    cmd(BMPM_CONV_T, 8'h00, 8'h00, '0, 1'b1);
    chk_ok(ct, 1'b1);
    rd(BMPM_RD_MEM, ADDR_STAT_LO, 8'h01);
    repeat (12) @(posedge i_clk);
    rd(BMPM_RD_MEM, ADDR_TEMP_LO, 8'h10);
    rd(BMPM_RD_MEM, ADDR_TEMP_HI, 8'h19);
    cmd(BMPM_CONV_V, 8'h00, 8'h00, '0, 1'b1);
    chk_ok(cv, 1'b1);
    rd(BMPM_RD_MEM, ADDR_STAT_LO, 8'h08);
    repeat (12) @(posedge i_clk);
    rd(BMPM_RD_MEM, ADDR_VOLT_LO, 8'hf4);
    rd(BMPM_RD_MEM, ADDR_VOLT_HI, 8'h01);
    rd(BMPM_RD_MEM, ADDR_STAT_LO, 8'h00);
    rd(BMPM_RD_MEM, ADDR_STAT_HI, 8'hff);
    cmd(BMPM_CYC_INC, 8'h00, 8'h00, '0, 1'b1);
    cmd(BMPM_CYC_INC, 8'h00, 8'h00, '0, 1'b1);
    rd(BMPM_RD_MEM, ADDR_CYC_LO, 8'h02);
    rd(BMPM_RD_MEM, ADDR_CYC_HI, 8'h00);
    cmd(BMPM_CYC_CLR, 8'h00, 8'h00, '0, 1'b1);
    rd(BMPM_RD_MEM, ADDR_CYC_LO, 8'h00);
    @(posedge i_clk);
    i_parasite <= 1'b1;
    repeat (4) @(posedge i_clk);
    cmd(BMPM_ROM_READ, 8'h00, 8'h00, '0, 1'b1);
    chk_val(rsp.rom_id, MY_ID);
    rd(BMPM_RD_MEM, 8'h27, 8'hc3);
    cmd(BMPM_WR_SP, 8'h00, 8'h33, '0, 1'b0);
    print_verdict();
  end
endmodule : test_battery_monitor_paged_memory
